/* File: core/ihp_decode_map.vh */
// Constants for the ISA host port decode block: port offsets, control
// byte fields, strap weights, serial converter timing.
// Assumes inclusion by bare name from core design files.
`ifndef IHP_DECODE_MAP_VH
`define IHP_DECODE_MAP_VH

// ==========================================================
// Port offsets from the strap base
`define IHP_OFS_CTRL 1'h0
`define IHP_OFS_HIADDR 1'h1

// ==========================================================
// Control byte fields
`define IHP_CTRL_PAGE_LO 0
`define IHP_CTRL_PAGE_HI 1
`define IHP_CTRL_A14 2
`define IHP_CTRL_A15 3
`define IHP_CTRL_RESET 4
`define IHP_CTRL_PROCINT 5
`define IHP_CTRL_HOSTEN 6
`define IHP_CTRL_CLKEN 7
`define IHP_CTRL_RESET_VAL 8'h00
`define IHP_HIADDR_RESET_VAL 8'h00

// ==========================================================
// Strap weights, bits 2 to 9 of the port address
`define IHP_STRAP_LSB 2

// ==========================================================
// Converter serial timing
`define IHP_SAMPLE_BITS 5'h10
`define IHP_SHIFT_DIV 4'h9
`define IHP_FIFO_DEPTH 8
`define IHP_FIFO_AW 3

// ==========================================================
// Request line codes, one hot over 11 lines
`define IHP_IRQ_LINES 11

`endif

/* File: core/ihp_fifo.v */
// Converter sample queue holder; the queue module sits beside its
// only user in ihp_host_port.v, so this file carries no logic.

/* File: core/ihp_host_port.v */
// ISA host port decode: I/O pair, memory page match, request line,
// converter serial output and link pins.
// Assumes ISA strobes already synchronous to mclk, straps static.
//
// Behaviour
// RULE1: Port base selectable 0 to 3FF hex in steps of four by straps.
// RULE2: Base is the sum of installed strap weights 4 through 200 hex.
// RULE3: Only base and base plus one are decoded; others ignored.
// RULE4: Second mark active falling by default; strap picks rising.
// RULE5: Software mode takes memory base from the written upper latch.
// RULE6: Hardware mode ignores the latch and uses eight address straps.
// RULE7: Address bits 23..16 matched against base select the 64K page.
// RULE8: Each memory strap presents a one or a zero, never open.
// RULE9: Installer sets page 0D0000h unless told otherwise.
// RULE10: Interrupt on one strap-picked line; request 9 appears as 2.
// RULE11: Three-bit channel address and enables for demuxes 0 to 3.
// RULE12: 16-bit samples sent serially as complementary clock, data, load.
// RULE13: Load pair pulses after all serial bits are shifted.
// RULE14: One ready line per remote unit, units 0 to 7.
// RULE15: One shared two-way differential link pair with remote units.
// RULE16: Serial transmit to time receiver, reply on separate input.
// RULE17: Second mark routed to the communications controller input.
// RULE18: Base port holds a readable control byte with listed fields.
// RULE19: Base plus one holds readable upper memory address latch.
// RULE20: In hardware mode latch writes never alter memory decode.
`timescale 1ns/10ps
`default_nettype none
`include "ihp_decode_map.vh"
module ihp_host_port (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Host I/O cycle
	input wire [9:0] ioAddr,
	input wire ioWrite,
	input wire ioRead,
	input wire [7:0] ioWrData,
	output reg [7:0] ioRdData,
	output wire ioSelect,
	// Host memory cycle
	input wire [23:16] memAddrHi,
	output wire memSelect,
	// Straps
	input wire [7:0] portStrap,
	input wire memModeSoft,
	input wire [7:0] memStrap,
	input wire markRising,
	input wire [10:0] irqStrap,
	// Processor side
	input wire procIrq,
	output wire [10:0] hostIrq,
	output wire procReset,
	output wire procInterrupt,
	output wire [1:0] memPage,
	output wire [1:0] memA15A14,
	output wire procClockEnable,
	output reg secondMarkEvent,
	output wire secondMarkToCtl,
	// Converter samples
	input wire sampleValid,
	output wire sampleReady,
	input wire [15:0] sampleData,
	input wire [2:0] sampleChannel,
	input wire [1:0] sampleDemux,
	// Converter pins
	output reg [2:0] converter_channel_addr,
	output reg [3:0] demux_select_enable,
	output reg converter_shift_clk_pos,
	output reg converter_shift_clk_neg,
	output reg converter_serial_bit_pos,
	output reg converter_serial_bit_neg,
	output reg converter_load_pos,
	output reg converter_load_neg,
	// Remote units and link
	input wire [7:0] remote_unit_ready,
	output wire [7:0] remoteReady,
	input wire linkTxData,
	input wire linkTxEnable,
	output wire linkRxData,
	input wire shared_link_pair_in,
	output wire shared_link_pair_pos,
	output wire shared_link_pair_neg,
	output wire shared_link_pair_oe,
	// Time receiver
	input wire timeTx,
	output wire timeRx,
	output wire time_rx_serial_out,
	input wire time_rx_serial_in,
	input wire second_mark_pulse
);
	// ==========================================================
	// Registers and decode
	localparam ST_IDLE = 2'h0;
	localparam ST_SHIFT = 2'h1;
	localparam ST_LOAD = 2'h2;

	reg [7:0] ctrl;
	reg [7:0] hiAddr;
	reg [1:0] state;
	reg [3:0] divCnt;
	reg [4:0] bitCnt;
	reg [15:0] shiftReg;
	reg clkPhase;
	reg markPrev;
	wire [9:0] portBase;
	wire hitCtrl;
	wire hitHi;
	wire [7:0] pageBase;
	wire divTick;
	wire fifoValid;
	wire fifoReady;
	wire [20:0] fifoData;
	wire markLevel;

	// Sum of strap weights; weights are single bits 2..9
	assign portBase = {portStrap, 2'h0}; // RULE1 RULE2

	// Port match helper
	function portHit;
		input [9:0] addr;
		input [9:0] base;
		input offs;
		begin
			portHit = (addr == base + {9'h000, offs});
		end
	endfunction

	assign hitCtrl = portHit(ioAddr, portBase, `IHP_OFS_CTRL); // RULE3
	assign hitHi = portHit(ioAddr, portBase, `IHP_OFS_HIADDR); // RULE3
	assign ioSelect = (ioRead || ioWrite) && (hitCtrl || hitHi); // RULE3

	// Register writes
	always @(posedge mclk) begin
		if (rst) begin
			ctrl <= `IHP_CTRL_RESET_VAL;
			hiAddr <= `IHP_HIADDR_RESET_VAL;
		end else if (ioWrite && hitCtrl) begin
			ctrl <= ioWrData; // RULE18
		end else if (ioWrite && hitHi) begin
			hiAddr <= ioWrData; // RULE19
		end
	end

	// Read data held in flops; unmatched reads return zero
	always @(posedge mclk) begin
		if (rst)
			ioRdData <= 8'h00;
		else if (ioRead && hitCtrl)
			ioRdData <= ctrl; // RULE18
		else if (ioRead && hitHi)
			ioRdData <= hiAddr; // RULE19
		else
			ioRdData <= 8'h00;
	end

	// Control fields out to the processor side
	assign memPage = {ctrl[`IHP_CTRL_PAGE_HI], ctrl[`IHP_CTRL_PAGE_LO]};
	assign memA15A14 = {ctrl[`IHP_CTRL_A15], ctrl[`IHP_CTRL_A14]};
	assign procReset = ctrl[`IHP_CTRL_RESET];
	assign procInterrupt = ctrl[`IHP_CTRL_PROCINT];
	assign procClockEnable = ctrl[`IHP_CTRL_CLKEN];

	// ==========================================================
	// Memory page match
	// Straps give hard 1/0 per bit, so no open level needs handling
	assign pageBase = memModeSoft ? hiAddr : memStrap; // RULE5 RULE6 RULE8 RULE20
	assign memSelect = (memAddrHi == pageBase); // RULE7

	// Request line: the strap bit picks the line, gated by enable.
	// Line 0 drives request 9, which the host sees as request 2.
	assign hostIrq = irqStrap & {`IHP_IRQ_LINES{procIrq &
		ctrl[`IHP_CTRL_HOSTEN]}}; // RULE10

	// ==========================================================
	// Second mark edge, polarity by strap
	assign markLevel = second_mark_pulse ^ ~markRising; // RULE4
	assign secondMarkToCtl = second_mark_pulse; // RULE17
	always @(posedge mclk) begin
		if (rst) begin
			markPrev <= markLevel;
			secondMarkEvent <= 1'b0;
		end else begin
			markPrev <= markLevel;
			secondMarkEvent <= markLevel && !markPrev; // RULE4
		end
	end

	// ==========================================================
	// Remote units, link pair, time receiver
	assign remoteReady = remote_unit_ready; // RULE14
	assign shared_link_pair_pos = linkTxData; // RULE15
	assign shared_link_pair_neg = ~linkTxData; // RULE15
	assign shared_link_pair_oe = linkTxEnable; // RULE15
	assign linkRxData = shared_link_pair_in; // RULE15
	assign time_rx_serial_out = timeTx; // RULE16
	assign timeRx = time_rx_serial_in; // RULE16

	// ==========================================================
	// Converter sample queue
	ihp_fifo #(
		.WIDTH(21),
		.DEPTH(`IHP_FIFO_DEPTH),
		.AW(`IHP_FIFO_AW)
	) sampleQueue (
		.mclk(mclk),
		.rst(rst),
		.inValid(sampleValid),
		.inReady(sampleReady),
		.inData({sampleDemux, sampleChannel, sampleData}),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoData)
	);

	// Queue drains only when the shifter is idle, so it back-fills
	assign fifoReady = (state == ST_IDLE);
	assign divTick = (divCnt == `IHP_SHIFT_DIV);

	// Half-bit divider; runs always so tick spacing stays fixed
	always @(posedge mclk) begin
		if (rst || divTick)
			divCnt <= 4'h0;
		else
			divCnt <= divCnt + 4'h1;
	end

	// Shifter: MSB first, data changes on falling shift clock
	always @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			bitCnt <= 5'h00;
			shiftReg <= 16'h0000;
			clkPhase <= 1'b0;
			converter_channel_addr <= 3'h0;
			demux_select_enable <= 4'h0;
			converter_shift_clk_pos <= 1'b0;
			converter_shift_clk_neg <= 1'b1;
			converter_serial_bit_pos <= 1'b0;
			converter_serial_bit_neg <= 1'b1;
			converter_load_pos <= 1'b0;
			converter_load_neg <= 1'b1;
		end else begin
			case (state)
			ST_IDLE: begin
				converter_load_pos <= 1'b0;
				converter_load_neg <= 1'b1;
				if (fifoValid) begin
					shiftReg <= fifoData[15:0];
					converter_channel_addr <= fifoData[18:16]; // RULE11
					demux_select_enable <= 4'h1 << fifoData[20:19]; // RULE11
					bitCnt <= 5'h00;
					clkPhase <= 1'b0;
					state <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (divTick) begin
					clkPhase <= ~clkPhase;
					converter_shift_clk_pos <= clkPhase; // RULE12
					converter_shift_clk_neg <= ~clkPhase; // RULE12
					if (!clkPhase) begin
						converter_serial_bit_pos <= shiftReg[15]; // RULE12
						converter_serial_bit_neg <= ~shiftReg[15]; // RULE12
						shiftReg <= {shiftReg[14:0], 1'b0};
						converter_shift_clk_pos <= 1'b0;
						converter_shift_clk_neg <= 1'b1;
						clkPhase <= 1'b1;
					end else if (bitCnt == `IHP_SAMPLE_BITS - 5'h01) begin
						state <= ST_LOAD;
					end else begin
						bitCnt <= bitCnt + 5'h01;
					end
				end
			end
			ST_LOAD: begin
				if (divTick) begin
					converter_shift_clk_pos <= 1'b0;
					converter_shift_clk_neg <= 1'b1;
					converter_load_pos <= 1'b1; // RULE13
					converter_load_neg <= 1'b0; // RULE13
					demux_select_enable <= 4'h0;
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule

// ==========================================================
// Converter sample queue
// Flop FIFO; refuses when full and never overwrites, so a slow
// shifter only holds the filling side back.
module ihp_fifo #(
	parameter WIDTH = 19,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Fill side
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// Drain side
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0] count;
	wire doWrite;
	wire doRead;

	// ==========================================================
	// Flags
	assign inReady = (count != DEPTH[AW:0]);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData = mem[rdPtr];
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;

	// Storage and pointers
	always @(posedge mclk) begin
		if (rst) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (doWrite) begin
				mem[wrPtr] <= inData;
				wrPtr <= wrPtr + 1'b1;
			end
			if (doRead)
				rdPtr <= rdPtr + 1'b1;
			if (doWrite && !doRead)
				count <= count + 1'b1;
			else if (doRead && !doWrite)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verif/ihp_converter_model.sv */
// Far-side converter model: shifts serial bits, latches on load.
// Assumes the normal-phase pins of ihp_host_port.
`timescale 1ns/10ps
`default_nettype none
module ihp_converter_model (
	// Converter pins
	input wire logic clkPos,
	input wire logic bitPos,
	input wire logic loadPos,
	input wire logic [2:0] chan,
	input wire logic [3:0] en,
	// Captured word count
	output var logic [7:0] count
);
	logic [15:0] shiftReg;
	logic [6:0] tag;
	logic [15:0] words [0:31];
	logic [6:0] tags [0:31];
	initial count = 8'h00;
	// Bits enter MSB first on the rising clock
	always @(posedge clkPos) begin
		shiftReg <= {shiftReg[14:0], bitPos};
		tag <= {chan, en};
	end
	// Enables may drop at load, so the tag is kept from the last bit
	always @(posedge loadPos) begin
		words[count] <= shiftReg;
		tags[count] <= tag;
		count <= count + 8'h01;
	end
endmodule
`default_nettype wire

/* File: verif/ihp_host_port_monitor.sv */
// Checker on the host port pins.
// Assumes binding into ihp_host_port.
`timescale 1ns/10ps
`default_nettype none
module ihp_monitor (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Host side
	input wire [9:0] ioAddr,
	input wire ioWrite,
	input wire ioRead,
	input wire ioSelect,
	input wire [7:0] ioRdData,
	input wire [7:0] portStrap,
	input wire memModeSoft,
	input wire [7:0] memStrap,
	input wire [23:16] memAddrHi,
	input wire memSelect,
	input wire [10:0] irqStrap,
	input wire [10:0] hostIrq,
	// Mark and converter
	input wire markRising,
	input wire second_mark_pulse,
	input wire secondMarkEvent,
	input wire converter_shift_clk_pos,
	input wire converter_shift_clk_neg,
	input wire converter_serial_bit_pos,
	input wire converter_serial_bit_neg,
	input wire converter_load_pos,
	input wire converter_load_neg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire logic hit;
	// Base and base plus one only
	assign hit = ioAddr[9:2] == portStrap && !ioAddr[1];
	sequence s_load;
		$rose(converter_load_pos);
	endsequence
	a_port_decode: assert property (ioSelect == ((ioRead | ioWrite) && hit))
		else $error("port decode wrong");
	a_miss_read: assert property (ioRead && !hit |=> ioRdData == 8'h00)
		else $error("missed read not zero");
	a_mem_hard: assert property (!memModeSoft |->
		memSelect == (memAddrHi == memStrap))
		else $error("strap page wrong");
	a_irq_line: assert property ((hostIrq & ~irqStrap) == 11'h000)
		else $error("unpicked line driven");
	a_mark_rise: assert property (markRising && $rose(second_mark_pulse)
		|-> ##[1:2] secondMarkEvent)
		else $error("rising mark lost");
	a_mark_fall: assert property (!markRising && $fell(second_mark_pulse)
		|-> ##[1:2] secondMarkEvent)
		else $error("falling mark lost");
	a_pair_compl: assert property (converter_shift_clk_neg != converter_shift_clk_pos
		&& converter_serial_bit_neg != converter_serial_bit_pos
		&& converter_load_neg != converter_load_pos)
		else $error("pair not complementary");
	a_load_once: assert property (s_load |=> !converter_load_pos)
		else $error("load wider than one cycle");
endmodule
bind ihp_host_port ihp_monitor i_mon (.*);
`default_nettype wire

/* File: verif/isa_host_port_decode_tb.sv */
// Testbench for ihp_host_port, one task per scenario.
// Assumes the converter model and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module isa_host_port_decode_tb;
	logic mclk, rst, ioWrite, ioRead, memModeSoft, markRising, procIrq;
	logic sampleValid, linkTxData, linkTxEnable, shared_link_pair_in, timeTx;
	logic time_rx_serial_in, second_mark_pulse, ioSelect, memSelect, procReset;
	logic procInterrupt, procClockEnable, secondMarkEvent, secondMarkToCtl;
	logic sampleReady, converter_shift_clk_pos, converter_shift_clk_neg;
	logic converter_serial_bit_pos, converter_serial_bit_neg, converter_load_pos;
	logic converter_load_neg, linkRxData, shared_link_pair_pos, timeRx;
	logic shared_link_pair_neg, shared_link_pair_oe, time_rx_serial_out;
	logic [9:0] ioAddr;
	logic [7:0] ioWrData, ioRdData, portStrap, memStrap, remote_unit_ready;
	logic [7:0] remoteReady, cnt;
	logic [23:16] memAddrHi;
	logic [10:0] irqStrap, hostIrq;
	logic [15:0] sampleData;
	logic [2:0] sampleChannel, converter_channel_addr;
	logic [1:0] sampleDemux, memPage, memA15A14;
	logic [3:0] demux_select_enable;
	int errors = 0, samples_checked = 0, n, k;
	ihp_host_port i_dut (.*);
	ihp_converter_model i_model (.clkPos(converter_shift_clk_pos),
		.bitPos(converter_serial_bit_pos), .loadPos(converter_load_pos),
		.chan(converter_channel_addr), .en(demux_select_enable), .count(cnt));
	// ==========================================================
	// Clock, bus tasks, closing
	initial mclk = 0;
	always #2.5 mclk = ~mclk;
	task wr(input [9:0] a, input [7:0] d);
		@(negedge mclk); ioAddr = a; ioWrData = d; ioWrite = 1;
		@(negedge mclk); ioWrite = 0;
	endtask
	// Read data stands one cycle, so it is judged at the next fall
	task rd(input [9:0] a, input [7:0] e);
		@(negedge mclk); ioAddr = a; ioRead = 1;
		@(negedge mclk); ioRead = 0; `CHK(ioRdData, e)
	endtask
	task mchk(input [7:0] a, input e);
		@(negedge mclk); memAddrHi = a; #1 `CHK(memSelect, e)
	endtask
	task results;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task t_ports;
		rd(10'h000, 8'h00);
		portStrap = 8'h8d;
		wr(10'h234, 8'hb5);
		`CHK({procClockEnable, procInterrupt, procReset, memA15A14, memPage}, 7'h75)
		wr(10'h235, 8'h3c);
		wr(10'h236, 8'h00);
		wr(10'h230, 8'h00);
		rd(10'h234, 8'hb5);
		rd(10'h236, 8'h00);
		for (k = 0; k < 8; k++) begin
			portStrap = 8'h01 << k;
			rd((10'h004 << k) + 10'h001, 8'h3c);
		end
		portStrap = 8'hff;
		rd(10'h3fd, 8'h3c);
		$display("done ports");
	endtask
	task t_mem;
		portStrap = 8'h8d; memStrap = 8'h0d;
		mchk(8'h0d, 1);
		mchk(8'h3c, 0);
		memModeSoft = 1;
		mchk(8'h3c, 1);
		mchk(8'h0d, 0);
		wr(10'h235, 8'h0e);
		mchk(8'h0e, 1);
		memModeSoft = 0;
		mchk(8'h0e, 0);
		$display("done memory");
	endtask
	task t_irq;
		wr(10'h234, 8'h40); procIrq = 1;
		for (k = 0; k < 11; k++) begin
			@(negedge mclk); irqStrap = 11'h001 << k;
			#1 `CHK(hostIrq, irqStrap)
		end
		wr(10'h234, 8'h00);
		#1 `CHK(hostIrq, 11'h000)
		$display("done irq");
	endtask
	task t_mark;
		for (k = 0; k < 2; k++) begin
			@(negedge mclk); markRising = k[0]; second_mark_pulse = !k[0];
			repeat (3) @(negedge mclk);
			for (int e = 1; e >= 0; e--) begin
				second_mark_pulse = e[0] ~^ k[0]; n = 0;
				repeat (4) begin @(negedge mclk); n += secondMarkEvent; end
				`CHK(n, e)
				`CHK(secondMarkToCtl, second_mark_pulse)
			end
		end
		$display("done mark");
	endtask
	task t_pass;
		for (k = 0; k < 8; k++) begin
			@(negedge mclk); remote_unit_ready = 8'h01 << k;
			{shared_link_pair_in, linkTxEnable, linkTxData} = k[2:0];
			{time_rx_serial_in, timeTx} = k[1:0];
			#1 `CHK({remoteReady, linkRxData, shared_link_pair_pos, shared_link_pair_neg,
				shared_link_pair_oe, time_rx_serial_out, timeRx}, {remote_unit_ready,
				k[2], k[0], !k[0], k[1], k[0], k[1]})
		end
		$display("done pass");
	endtask
	// Fill until refused while the shifter drains slowly behind
	task t_conv;
		n = 0;
		forever begin
			@(negedge mclk);
			if (sampleReady !== 1'b1 || n == 20) break;
			sampleValid = 1; sampleData = 16'h8001 + n[15:0] * 16'h0f0f;
			sampleChannel = n[2:0]; sampleDemux = n[1:0]; n++;
		end
		sampleValid = 0;
		`CHK(sampleReady, 1'b0)
		`CHK(n > 8, 1'b1)
		for (k = 0; cnt != n[7:0] && k < 20000; k++) @(negedge mclk);
		`CHK(cnt, n[7:0])
		for (k = 0; k < n; k++) begin
			`CHK(i_model.words[k], 16'h8001 + k[15:0] * 16'h0f0f)
			`CHK(i_model.tags[k], {k[2:0], 4'h1 << k[1:0]})
		end
		`CHK(sampleReady, 1'b1)
		$display("done converter");
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{rst, ioWrite, ioRead, memModeSoft, markRising, procIrq, sampleValid} = 7'h40;
		{linkTxData, linkTxEnable, shared_link_pair_in, timeTx} = 4'h0;
		{time_rx_serial_in, second_mark_pulse, ioAddr, ioWrData} = 20'h00000;
		{memAddrHi, portStrap, memStrap, remote_unit_ready} = 32'h00000000;
		{irqStrap, sampleData, sampleChannel, sampleDemux} = 32'h00000000;
		repeat (4) @(negedge mclk);
		rst = 0;
		// No false mark edge may follow the reset state
		@(negedge mclk);
		`CHK(secondMarkEvent, 1'b0)
		t_ports; t_mem; t_irq; t_mark; t_pass; t_conv;
		results;
	end
	initial begin
		#100us;
		errors++;
		results;
	end
endmodule
`default_nettype wire
